// >>> ecc_regs.svh
`ifndef ECC_REGS_SVH
`define ECC_REGS_SVH

// ==========================================================================
// Register map
// ==========================================================================
`define ECC_ADDR_MODE    8'h00
`define ECC_ADDR_START   8'h04
`define ECC_ADDR_STOP    8'h08
`define ECC_ADDR_STATUS  8'h0c
`define ECC_RESP_OKAY    2'b00
`define ECC_RESP_SLVERR  2'b10
`define ECC_PROGRAM_SELECT_USER    3'h4
`define ECC_SIF_SENSE    2'h2

// ==========================================================================
// Condition codes and figures
// ==========================================================================
`define ECC_CODE_NONE    4'h0
`define ECC_CODE_TIME    4'h1
`define ECC_EXT_MAX      10'h10e
`define ECC_MIN_PER_TNTH 11'h006
`define ECC_RPT_S8       11'h00a
`define ECC_RPT_S9       11'h01e
`define ECC_RPT_S10      11'h03c
`define ECC_RPT_S11      11'h078
`define ECC_RPT_P8       11'h001
`define ECC_RPT_P9       11'h003
`define ECC_RPT_P10      11'h006
`define ECC_RPT_P11      11'h00c
`define ECC_CNT_MAX      11'h7ff
`define ECC_CLK_MHZ      100
`define ECC_EVAL_US      1000
`define ECC_TICK_W       17

`endif

// >>> ecc_pkg.sv
`default_nettype none
`include "ecc_regs.svh"

package ecc_pkg;

	typedef enum logic {
		ECC_IDLE   = 1'b0,
		ECC_ACTIVE = 1'b1
	} ecc_ev_e;

	typedef struct packed {
		ecc_ev_e                 ev;
		logic                    blk;
		logic                    s_prev;
		logic [`ECC_TICK_W-1:0]  tick_cnt;
		logic                    tick;
		logic [10:0]             tod_prev;
		logic                    min_pend;
		logic [10:0]             rep_cnt;
		logic [10:0]             run_cnt;
		logic [9:0]              pan;
		logic                    chg_min;
		logic                    pb1;
		logic                    pb2;
		logic [2:0]              program_select;
		logic [1:0]              sif;
		logic [3:0]              scode;
		logic [9:0]              sval;
		logic [3:0]              pcode;
		logic [9:0]              pval;
		logic                    awready;
		logic                    wready;
		logic                    aw_have;
		logic                    w_have;
		logic [7:0]              awaddr;
		logic [31:0]             wdata;
		logic [3:0]              wstrb;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    arready;
		logic                    rvalid;
		logic [31:0]             rdata;
		logic [1:0]              rresp;
		logic                    ev_on;
		logic                    ev_off;
	} ecc_state_s;

endpackage : ecc_pkg

`default_nettype wire

// >>> ecc_ctrl.sv
// Operation
// - Start only on start rising with aux active.
// - Further starts blocked while start stays active.
// - Start going inactive clears the block.
// - Active stop at start edge prevents start.
// - Start code 0 means always active.
// - Stop code 0 means never active.
// - Code 1: time of day above setting.
// - Start codes 8-11 repeat at fixed intervals.
// - Stop codes 8-11 end after fixed run times.
// - Start codes 14/15 repeat at programmed rate.
// - Stop codes 14/15 end after run time.
// - Codes 6/7 combine push-button with time.
// - Codes 4/5 compare selected external voltage.
// - Codes 2/3 compare panel voltage, may delay.
// - Codes 12/13 compare battery voltage.
// - Stop time below start time means next day.
// - Settings editable only in program 4.
// - Idle event starts with start, aux, threshold.
// - Stop or aux/threshold loss ends event.
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ecc_regs.svh"

module ecc_ctrl #(
	parameter logic [`ECC_TICK_W-1:0] EVAL_CYCLES =
		`ECC_TICK_W'(`ECC_EVAL_US * `ECC_CLK_MHZ)
) (
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	// Controller state and measurements.
	input  wire logic [10:0] time_of_day_min,
	input  wire logic [9:0]  panel_voltage,
	input  wire logic [9:0]  sense_voltage,
	input  wire logic [9:0]  bus_ext_voltage,
	input  wire logic [9:0]  battery_voltage,
	input  wire logic        charge_switch_on,
	input  wire logic        aux_state_condition,
	input  wire logic        threshold_condition,
	input  wire logic        push_button_input,
	// Switched output.
	output var  logic        event_out,
	output var  logic        event_inactive_indication,
	// AXI4-Lite slave.
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// ======================================================================
	// Helpers
	// ======================================================================
	function automatic logic [10:0] to_min(input logic [9:0] tenths);
		to_min = 11'({1'b0, tenths} * `ECC_MIN_PER_TNTH);
	endfunction : to_min

	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		merge = (old & ~m) | (nw & m);
	endfunction : merge

	function automatic logic [10:0] rep_int(input logic [3:0] code,
			input logic is_stop, input logic [9:0] val);
		rep_int = `ECC_CNT_MAX;
		unique case (code)
			4'h8: rep_int = is_stop ? `ECC_RPT_P8 : `ECC_RPT_S8;
			4'h9: rep_int = is_stop ? `ECC_RPT_P9 : `ECC_RPT_S9;
			4'ha: rep_int = is_stop ? `ECC_RPT_P10 : `ECC_RPT_S10;
			4'hb: rep_int = is_stop ? `ECC_RPT_P11 : `ECC_RPT_S11;
			4'he: rep_int = {1'b0, val};
			4'hf: rep_int = to_min(val);
			default: rep_int = `ECC_CNT_MAX;
		endcase
	endfunction : rep_int

	ecc_pkg::ecc_state_s q;
	ecc_pkg::ecc_state_s d;

	logic [9:0] ext_v;
	logic       s_now;
	logic       p_now;
	logic       s_edge;
	logic       wrap;
	logic       go_on;
	logic       go_off;
	logic [3:0] s_code;
	logic [3:0] p_code;

	// Shared decoder for both start and stop selections.
	function automatic logic cond(input logic [3:0] code,
			input logic [9:0] val, input logic [10:0] cnt,
			input logic is_stop);
		logic tgt;
		tgt = time_of_day_min > to_min(val);
		unique case (code)
			4'h0: cond = !is_stop;
			4'h1: cond = tgt;
			4'h2: cond = q.pan > val;
			4'h3: cond = q.pan < val;
			4'h4: cond = ext_v > val;
			4'h5: cond = ext_v < val;
			4'h6: cond = q.pb2 && tgt;
			4'h7: cond = !q.pb2 && tgt;
			4'h8, 4'h9, 4'ha, 4'hb:
				cond = tgt && cnt >= rep_int(code, is_stop, val);
			4'hc: cond = battery_voltage > val;
			4'hd: cond = battery_voltage < val;
			4'he, 4'hf:
				cond = cnt >= rep_int(code, is_stop, val);
			default: cond = 1'b0;
		endcase
	endfunction : cond

	// ======================================================================
	// Condition evaluation
	// ======================================================================
	always_comb begin
		// The sense input cannot read beyond its range, so it is clamped.
		if (q.sif == `ECC_SIF_SENSE) begin
			ext_v = (sense_voltage > `ECC_EXT_MAX) ? `ECC_EXT_MAX
				: sense_voltage;
		end else begin
			ext_v = bus_ext_voltage;
		end
		s_code = (q.program_select == `ECC_PROGRAM_SELECT_USER) ? q.scode : `ECC_CODE_NONE;
		p_code = (q.program_select == `ECC_PROGRAM_SELECT_USER) ? q.pcode : `ECC_CODE_NONE;
		s_now = cond(s_code, q.sval, q.rep_cnt, 1'b0);
		wrap = s_code == `ECC_CODE_TIME && p_code == `ECC_CODE_TIME
			&& q.pval < q.sval;
		if (wrap) begin
			p_now = time_of_day_min > to_min(q.pval)
				&& time_of_day_min <= to_min(q.sval);
		end else begin
			p_now = cond(p_code, q.pval, q.run_cnt, 1'b1);
		end
		// Code 0 has no edge to wait for, so it is exempt from the block.
		s_edge = (s_code == `ECC_CODE_NONE) ? 1'b1
			: (s_now && !q.s_prev && !q.blk);
		go_on = q.tick && q.ev == ecc_pkg::ECC_IDLE && s_now && s_edge
			&& !p_now && aux_state_condition
			&& threshold_condition;
		go_off = q.tick && q.ev == ecc_pkg::ECC_ACTIVE && (p_now
			|| !aux_state_condition || !threshold_condition);
	end

	// ======================================================================
	// Next state
	// ======================================================================
	always_comb begin
		logic        aw_ok;
		logic        w_ok;
		logic [7:0]  wa;
		logic [31:0] wd;
		logic [3:0]  ws;
		logic [31:0] cur;
		logic        hit;
		d = q;
		aw_ok = q.aw_have || (s_axi_awvalid && q.awready);
		w_ok = q.w_have || (s_axi_wvalid && q.wready);
		wa = q.aw_have ? q.awaddr : s_axi_awaddr;
		wd = q.w_have ? q.wdata : s_axi_wdata;
		ws = q.w_have ? q.wstrb : s_axi_wstrb;
		cur = 32'h0;
		hit = 1'b0;

		d.pb1 = push_button_input;
		d.pb2 = q.pb1;

		d.tick = q.tick_cnt == EVAL_CYCLES - 1'b1;
		d.tick_cnt = d.tick ? '0 : q.tick_cnt + 1'b1;
		d.tod_prev = time_of_day_min;
		d.min_pend = (q.min_pend && !q.tick)
			|| (time_of_day_min != q.tod_prev);

		if (!charge_switch_on) begin
			d.chg_min = 1'b0;
		end else if (q.tick && q.min_pend) begin
			d.chg_min = 1'b1;
		end
		// Panel voltage is sampled while the charge switch is off, or once it has stayed on past a minute change.
		if (q.tick && (!charge_switch_on || q.chg_min)) begin
			d.pan = panel_voltage;
		end

		if (q.tick) begin
			d.s_prev = s_now;
			if (q.min_pend && q.rep_cnt != `ECC_CNT_MAX) begin
				d.rep_cnt = q.rep_cnt + 1'b1;
			end
			if (q.min_pend && q.run_cnt != `ECC_CNT_MAX) begin
				d.run_cnt = q.run_cnt + 1'b1;
			end
			// The run timer only counts while the event is on, so an
			// old run cannot show up as an active stop at the next start.
			if (q.ev == ecc_pkg::ECC_IDLE) begin
				d.run_cnt = '0;
			end
			if (s_now && s_code >= 4'h8 && s_code != 4'hc
					&& s_code != 4'hd) begin
				d.rep_cnt = '0;
			end
			if (!s_now) begin
				d.blk = 1'b0;
			end else if (s_edge) begin
				d.blk = 1'b1;
			end
			if (go_on) begin
				d.ev = ecc_pkg::ECC_ACTIVE;
				d.run_cnt = '0;
			end else if (go_off) begin
				d.ev = ecc_pkg::ECC_IDLE;
			end
		end
		d.ev_on = d.ev == ecc_pkg::ECC_ACTIVE;
		d.ev_off = d.ev == ecc_pkg::ECC_IDLE;

		// AXI4-Lite write: address and data taken in either order.
		if (s_axi_awvalid && q.awready) begin
			d.aw_have = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready) begin
			d.w_have = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		if (aw_ok && w_ok && !q.bvalid) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = `ECC_RESP_OKAY;
			unique case (wa)
				`ECC_ADDR_MODE: begin
					cur = merge({26'h0, q.sif, 1'b0, q.program_select}, wd, ws);
					d.program_select = cur[2:0];
					d.sif = cur[5:4];
				end
				`ECC_ADDR_START: begin
					cur = merge({6'h0, q.sval, 12'h0, q.scode}, wd, ws);
					if (q.program_select == `ECC_PROGRAM_SELECT_USER) begin
						d.scode = cur[3:0];
						d.sval = cur[25:16];
					end
				end
				`ECC_ADDR_STOP: begin
					cur = merge({6'h0, q.pval, 12'h0, q.pcode}, wd, ws);
					if (q.program_select == `ECC_PROGRAM_SELECT_USER) begin
						d.pcode = cur[3:0];
						d.pval = cur[25:16];
					end
				end
				`ECC_ADDR_STATUS: d.bresp = `ECC_RESP_OKAY;
				default: d.bresp = `ECC_RESP_SLVERR;
			endcase
		end
		d.awready = !d.aw_have && !d.bvalid;
		d.wready = !d.w_have && !d.bvalid;

		// AXI4-Lite read.
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && q.arready) begin
			d.rvalid = 1'b1;
			d.rresp = `ECC_RESP_OKAY;
			unique case (s_axi_araddr)
				`ECC_ADDR_MODE: d.rdata = {26'h0, q.sif, 1'b0, q.program_select};
				`ECC_ADDR_START:
					d.rdata = {6'h0, q.sval, 12'h0, q.scode};
				`ECC_ADDR_STOP:
					d.rdata = {6'h0, q.pval, 12'h0, q.pcode};
				`ECC_ADDR_STATUS: begin
					hit = 1'b1;
					d.rdata = {26'h0, q.blk, threshold_condition,
						aux_state_condition, p_now, s_now, q.ev_on};
				end
				default: begin
					d.rdata = 32'h0;
					d.rresp = `ECC_RESP_SLVERR;
				end
			endcase
		end
		d.arready = !d.rvalid && !hit;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign event_out = q.ev_on;
	assign event_inactive_indication = q.ev_off;
	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;

	// ======================================================================
	// Checks
	// ======================================================================
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	sequence idle_tick_s;
		q.tick && q.ev == ecc_pkg::ECC_IDLE;
	endsequence
	sequence stop_seen_s;
		idle_tick_s ##0 p_now;
	endsequence

	start_edge_a: assert property ($rose(q.ev) |-> $past(s_now
		&& aux_state_condition && (s_code == 4'h0 || !q.s_prev)))
		else $error("start taken without a rising start");
	block_set_a: assert property ($rose(q.ev) && s_code != 4'h0
		|-> q.blk) else $error("start block not set");
	block_clr_a: assert property (q.tick && !s_now |=> !q.blk)
		else $error("start block not cleared");
	stop_prio_a: assert property (stop_seen_s |=>
		q.ev == ecc_pkg::ECC_IDLE) else $error("start despite stop");
	code_zero_a: assert property (s_code == 4'h0 |-> s_now
		&& (p_code != 4'h0 || !p_now))
		else $error("code zero misread");
	program_select_lock_a: assert property (q.program_select != `ECC_PROGRAM_SELECT_USER
		|-> s_code == 4'h0 && p_code == 4'h0)
		else $error("settings active outside user program");
	turn_on_a: assert property (go_on |=> ##1 event_out)
		else $error("event output did not turn on");
	turn_off_a: assert property (go_off |=> ##1
		event_inactive_indication) else $error("event did not end");
	tick_gap_a: assert property (q.tick |=> !q.tick)
		else $error("evaluation tick too frequent");

endmodule : ecc_ctrl
`default_nettype wire

// >>> ecc_load_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Switched load on the far side of the event output
// ==========================================================================
module ecc_load_model (
	// Clock and reset.
	input  wire logic ref_clk,
	input  wire logic reset_n,
	// Drive from the controller.
	input  wire logic event_out,
	input  wire logic event_inactive_indication,
	// Load state.
	output var  logic load_on_q
);
	// The coil only pulls in when both drive lines agree, so a glitch on one
	// of them, or the two lines stuck at the same level, leaves the load off.
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			load_on_q <= 1'b0;
		end else begin
			load_on_q <= event_out & ~event_inactive_indication;
		end
	end
endmodule : ecc_load_model

`default_nettype wire

// >>> event_condition_controller_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ecc_regs.svh"

module event_condition_controller_tb_top;
	logic        ref_clk, reset_n, chg, aux, thr, pb, ev, ev_n, load_on;
	logic [10:0] tod;
	logic [9:0]  pan, sns, bext, bat, te;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [1:0]  bresp, rresp, rs;
	logic [31:0] tw [10];
	int          errors, check_count;

	ecc_ctrl #(.EVAL_CYCLES(17'h00014)) uut (
		.ref_clk(ref_clk), .reset_n(reset_n), .time_of_day_min(tod),
		.panel_voltage(pan), .sense_voltage(sns), .bus_ext_voltage(bext),
		.battery_voltage(bat), .charge_switch_on(chg),
		.aux_state_condition(aux), .threshold_condition(thr),
		.push_button_input(pb), .event_out(ev),
		.event_inactive_indication(ev_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	ecc_load_model load (.ref_clk(ref_clk), .reset_n(reset_n),
		.event_out(ev), .event_inactive_indication(ev_n),
		.load_on_q(load_on));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// ======================================================================
	// Checking and bus tasks
	// ======================================================================
	task automatic print_verdict;
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge ref_clk);
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge ref_clk);
		chk({30'h0, bresp}, {30'h0, `ECC_RESP_OKAY});
		bready <= 1'b0;
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
			input logic [31:0] exp, input logic [1:0] er);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(posedge ref_clk);
		while (arready !== 1'b1) @(posedge ref_clk);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge ref_clk);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
		chk(rd & m, exp);
		chk({30'h0, rs}, {30'h0, er});
	endtask : rdchk

	// Three evaluation ticks plus the two flops behind each tick.
	task automatic evchk(input logic exp);
		repeat (70) @(posedge ref_clk);
		chk({31'h0, ev}, {31'h0, exp});
		chk({31'h0, ev_n}, {31'h0, ~exp});
		chk({31'h0, load_on}, {31'h0, exp});
	endtask : evchk

	// ======================================================================
	// Test sequence
	// ======================================================================
	initial begin
		errors = 0;
		check_count = 0;
		tw = '{32'h0000_0000, 32'h0032_0001, 32'h0064_0002, 32'h0064_0003,
			32'h0118_0004, 32'h0118_0005, 32'h0032_0006, 32'h0032_0007,
			32'h0078_000c, 32'h0078_000d};
		te = 10'b0101100111;
		{reset_n, chg, aux, thr, pb, tod, pan, sns, bext, bat} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'hf;
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		evchk(1'b0);
		for (int i = 0; i < 3; i++) begin
			rdchk(8'(4 * i), 32'hffff_ffff, 32'h0, `ECC_RESP_OKAY);
		end
		rdchk(8'h40, 32'hffff_ffff, 32'h0, `ECC_RESP_SLVERR);
		wr(`ECC_ADDR_START, 32'h0064_0001);
		rdchk(`ECC_ADDR_START, 32'hffff_ffff, 32'h0, `ECC_RESP_OKAY);
		aux <= 1'b1;
		thr <= 1'b1;
		evchk(1'b1);
		thr <= 1'b0;
		evchk(1'b0);
		// Window from 10.0 h to 5.0 h on the next day.
		wr(`ECC_ADDR_MODE, 32'h0000_0004);
		wr(`ECC_ADDR_START, 32'h0064_0001);
		wr(`ECC_ADDR_STOP, 32'h0032_0001);
		tod <= 11'h1f4;
		thr <= 1'b1;
		evchk(1'b0);
		tod <= 11'h262;
		evchk(1'b1);
		tod <= 11'h0c8;
		evchk(1'b1);
		tod <= 11'h136;
		evchk(1'b0);
		// Battery start above 12.0 V, stop below 14.0 V, then 11.0 V.
		wr(`ECC_ADDR_STOP, 32'h008c_000d);
		wr(`ECC_ADDR_START, 32'h0078_000c);
		bat <= 10'h082;
		evchk(1'b0);
		bat <= 10'h064;
		wr(`ECC_ADDR_STOP, 32'h006e_000d);
		evchk(1'b0);
		bat <= 10'h082;
		evchk(1'b1);
		rdchk(`ECC_ADDR_STATUS, 32'h3f, 32'h3b, `ECC_RESP_OKAY);
		aux <= 1'b0;
		evchk(1'b0);
		aux <= 1'b1;
		evchk(1'b0);
		aux <= 1'b0;
		bat <= 10'h064;
		evchk(1'b0);
		bat <= 10'h082;
		evchk(1'b0);
		aux <= 1'b1;
		evchk(1'b0);
		bat <= 10'h064;
		evchk(1'b0);
		bat <= 10'h082;
		evchk(1'b1);
		// Start condition per code; sense input clamps 30.0 V to 27.0 V.
		pan <= 10'h096;
		sns <= 10'h12c;
		bext <= 10'h032;
		pb <= 1'b1;
		wr(`ECC_ADDR_MODE, 32'h0000_0024);
		for (int i = 0; i < 10; i++) begin
			wr(`ECC_ADDR_START, tw[i]);
			repeat (60) @(posedge ref_clk);
			rdchk(`ECC_ADDR_STATUS, 32'h2, {30'h0, te[i], 1'b0},
				`ECC_RESP_OKAY);
		end
		wr(`ECC_ADDR_MODE, 32'h0000_0004);
		wr(`ECC_ADDR_START, 32'h0118_0005);
		repeat (60) @(posedge ref_clk);
		rdchk(`ECC_ADDR_STATUS, 32'h2, 32'h2, `ECC_RESP_OKAY);
		// Repeat start every 2 min, each run lasting 1 min.
		aux <= 1'b0;
		evchk(1'b0);
		wr(`ECC_ADDR_STOP, 32'h0001_000e);
		wr(`ECC_ADDR_START, 32'h0002_000e);
		aux <= 1'b1;
		evchk(1'b0);
		tod <= 11'h137;
		evchk(1'b0);
		tod <= 11'h138;
		evchk(1'b1);
		tod <= 11'h139;
		evchk(1'b0);
		tod <= 11'h13a;
		evchk(1'b1);
		// Repeat start every 10 min once past 0.0 h.
		wr(`ECC_ADDR_START, 32'h0000_0008);
		for (int i = 0; i < 10; i++) begin
			if (i == 9) evchk(1'b0);
			tod <= tod + 11'h001;
			repeat (25) @(posedge ref_clk);
		end
		evchk(1'b1);
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		print_verdict();
	end
endmodule : event_condition_controller_tb_top

`default_nettype wire
